// ===== include/omlr_pkg.sv
// Function
// - group bytes sit at offsets 20h and 21h
// - one byte access covers whole group, bit n
// - host load beats logic drive
// - load overrides preset, clear and clock
// - power-on reset clears all cells
// - warm reset keeps cell contents
// - mask bytes sit at offsets 22h and 23h
// - mask bit one blocks write, zero allows
// - set mask protects logic state machines
// - masks read 00h after any reset
// - group a drives port a or b
// - port c pins 0,1,5,6 take no cell
// - rising clock, active high level preset/clear
// - cell feeds pin, bus and feedback together
package omlr_pkg;

	// =========================================================
	// register map
	localparam logic [7:0] OMLR_OFS_GRP_A  = 8'h20;
	localparam logic [7:0] OMLR_OFS_GRP_B  = 8'h21;
	localparam logic [7:0] OMLR_OFS_MASK_A = 8'h22;
	localparam logic [7:0] OMLR_OFS_MASK_B = 8'h23;

	// =========================================================
	// reset values and fixed patterns
	localparam logic [7:0] OMLR_MASK_RST   = 8'h00;
	localparam logic       OMLR_CELL_RST   = 1'b0;
	localparam logic [7:0] OMLR_UNMAPPED   = 8'h00;
	// port c bits that may take a cell output (2,3,4,7)
	localparam logic [7:0] OMLR_PORTC_OK   = 8'h9C;

	// =========================================================
	// sizes
	localparam int         OMLR_GRP_W      = 8;
	localparam int         OMLR_NCELL      = 16;

endpackage

// ===== hdl/omlr_cell.sv
`timescale 1ns/10ps
module omlr_cell
	import omlr_pkg::*;
(
	// clock and resets
	input  wire logic clk_i,
	input  wire logic rst_i,
	input  wire logic por_i,
	// logic side
	input  wire logic d_i,
	input  wire logic pt_clk_i,
	input  wire logic preset_i,
	input  wire logic clear_i,
	// host load
	input  wire logic load_i,
	input  wire logic load_data_i,
	// cell state
	output logic      q_o
);

	// =========================================================
	// state
	typedef struct packed {
		logic q;
		logic clk_prev;
	} omlr_cell_s;

	omlr_cell_s s_q;
	omlr_cell_s s_d;
	logic       rise;

	assign rise = pt_clk_i & ~s_q.clk_prev;

	// next state: power-on, then warm reset hold, then host load, then clear, preset, clock
	always_comb begin
		s_d          = s_q;
		s_d.clk_prev = pt_clk_i;
		if (por_i) begin
			s_d.q = OMLR_CELL_RST;
		end else if (rst_i) begin
			s_d.q = s_q.q;
		end else if (load_i) begin
			s_d.q = load_data_i;
		end else if (clear_i) begin
			s_d.q = 1'b0;
		end else if (preset_i) begin
			s_d.q = 1'b1;
		end else if (rise) begin
			s_d.q = d_i;
		end
	end

	// warm reset only re-arms the edge detector, the cell holds
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			s_q.clk_prev <= 1'b1; // no false edge right after reset
			s_q.q        <= s_d.q;
		end else begin
			s_q <= s_d;
		end
	end

	assign q_o = s_q.q;

	// =========================================================
	// checks
	a_load_wins: assert property (@(posedge clk_i)
		load_i && !por_i |=> q_o == $past(load_data_i))
		else $error("host load did not win");

	a_clear_level: assert property (@(posedge clk_i) disable iff (rst_i)
		!por_i && !load_i && clear_i |=> !q_o)
		else $error("clear did not clear cell");

	a_warm_holds: assert property (@(posedge clk_i)
		rst_i && !por_i && !load_i && !clear_i && !preset_i |=> q_o == $past(q_o))
		else $error("warm reset changed cell");

endmodule

// ===== hdl/omlr_alloc.sv
`timescale 1ns/10ps
module omlr_alloc
	import omlr_pkg::*;
(
	// clock and reset
	input  wire logic       clk_i,
	input  wire logic       rst_i,
	// cells and routing
	input  wire logic [15:0] cell_q_i,
	input  wire logic [15:0] drive_en_i,
	input  wire logic [7:0]  a_to_port_a_i,
	input  wire logic [7:0]  b_to_port_c_i,
	input  wire logic        pkg80_i,
	// pins
	output logic [7:0]       port_a_o,
	output logic [7:0]       port_a_oe_o,
	output logic [7:0]       port_b_o,
	output logic [7:0]       port_b_oe_o,
	output logic [7:0]       port_c_o,
	output logic [7:0]       port_c_oe_o
);

	// =========================================================
	// state
	typedef struct packed {
		logic [7:0] a;
		logic [7:0] a_oe;
		logic [7:0] b;
		logic [7:0] b_oe;
		logic [7:0] c;
		logic [7:0] c_oe;
	} omlr_alloc_s;

	omlr_alloc_s s_q;
	omlr_alloc_s s_d;
	logic [7:0]  ga_en;
	logic [7:0]  gb_en;
	logic [7:0]  ga_to_a;
	logic [7:0]  gb_to_c;
	logic [7:0]  ga_to_b;

	// each cell goes to at most one pin; group a wins a shared b pin
	always_comb begin
		ga_en   = drive_en_i[7:0];
		gb_en   = drive_en_i[15:8];
		ga_to_a = a_to_port_a_i & {8{pkg80_i}};
		gb_to_c = b_to_port_c_i & OMLR_PORTC_OK;
		ga_to_b = ga_en & ~a_to_port_a_i;
		s_d.a    = cell_q_i[7:0];
		s_d.a_oe = ga_en & ga_to_a;
		s_d.c    = cell_q_i[15:8] & OMLR_PORTC_OK;
		s_d.c_oe = gb_en & gb_to_c;
		s_d.b_oe = ga_to_b | (gb_en & ~gb_to_c);
		s_d.b    = (ga_to_b & cell_q_i[7:0])
			| (~ga_to_b & cell_q_i[15:8]);
	end

	// pins registered so every top output leaves a flop
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign port_a_o    = s_q.a;
	assign port_a_oe_o = s_q.a_oe;
	assign port_b_o    = s_q.b;
	assign port_b_oe_o = s_q.b_oe;
	assign port_c_o    = s_q.c;
	assign port_c_oe_o = s_q.c_oe;

	// =========================================================
	// checks
	a_portc_reserved: assert property (@(posedge clk_i) disable iff (rst_i)
		(port_c_oe_o & ~OMLR_PORTC_OK) == 8'h00)
		else $error("reserved port c pin driven");

	a_porta_pkg: assert property (@(posedge clk_i) disable iff (rst_i)
		!pkg80_i |=> port_a_oe_o == 8'h00)
		else $error("port a driven on small package");

	a_one_pin: assert property (@(posedge clk_i) disable iff (rst_i)
		(port_a_oe_o & $past(ga_to_b)) == 8'h00)
		else $error("group a cell drives two pins");

endmodule

// ===== hdl/omlr_top.sv
`timescale 1ns/10ps
module omlr_top
	import omlr_pkg::*;
#(
	parameter int GRP_W = OMLR_GRP_W
)
(
	// clock and resets
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	input  wire logic        por_i,
	// host data bus, control register space
	input  wire logic        hsel_i,
	input  wire logic [7:0]  haddr_i,
	input  wire logic        hwr_i,
	input  wire logic        hrd_i,
	input  wire logic [7:0]  hwdata_i,
	output logic [7:0]       hrdata_o,
	output logic             hack_o,
	// product-term side, one bit per cell, group a in 7:0
	input  wire logic [15:0] cell_d_i,
	input  wire logic [15:0] cell_clk_i,
	input  wire logic [15:0] cell_preset_i,
	input  wire logic [15:0] cell_clear_i,
	output logic [15:0]      cell_fb_o,
	// pin routing
	input  wire logic [15:0] drive_en_i,
	input  wire logic [7:0]  a_to_port_a_i,
	input  wire logic [7:0]  b_to_port_c_i,
	input  wire logic        pkg80_i,
	// port pins
	output logic [7:0]       port_a_o,
	output logic [7:0]       port_a_oe_o,
	output logic [7:0]       port_b_o,
	output logic [7:0]       port_b_oe_o,
	output logic [7:0]       port_c_o,
	output logic [7:0]       port_c_oe_o
);

	// =========================================================
	// elaboration check
	generate
		if (GRP_W != 8) begin : g_bad_width
			$error("group width must be eight, one cell per bus bit");
		end
	endgenerate

	// =========================================================
	// state
	typedef struct packed {
		logic [7:0] mask_a;
		logic [7:0] mask_b;
		logic [7:0] rdata;
		logic       ack;
	} omlr_top_s;

	omlr_top_s   s_q;
	omlr_top_s   s_d;
	logic        wr_hit;
	logic        rd_hit;
	logic        wr_grp_a;
	logic        wr_grp_b;
	logic [15:0] load;
	logic [15:0] load_data;
	logic [15:0] cells;

	// =========================================================
	// host decode
	// a write in the same cycle as a read is taken as the write
	// a strobe still held in its own ack cycle is not taken twice
	always_comb begin
		wr_hit   = hsel_i & hwr_i & ~s_q.ack & ~rst_i & ~por_i;
		rd_hit   = hsel_i & hrd_i & ~hwr_i & ~s_q.ack & ~rst_i & ~por_i;
		wr_grp_a = wr_hit && (haddr_i == OMLR_OFS_GRP_A);
		wr_grp_b = wr_hit && (haddr_i == OMLR_OFS_GRP_B);
	end

	// per-cell load strobes, gated by the mask of the group
	// masked cells see no load, so their own logic keeps running
	always_comb begin
		load      = {({8{wr_grp_b}} & ~s_q.mask_b),
			({8{wr_grp_a}} & ~s_q.mask_a)};
		load_data = {hwdata_i, hwdata_i};
	end

	// =========================================================
	// register file
	always_comb begin
		s_d     = s_q;
		s_d.ack = wr_hit | rd_hit;
		if (wr_hit && haddr_i == OMLR_OFS_MASK_A) begin
			s_d.mask_a = hwdata_i;
		end
		if (wr_hit && haddr_i == OMLR_OFS_MASK_B) begin
			s_d.mask_b = hwdata_i;
		end
		if (rd_hit) begin
			unique case (haddr_i)
				OMLR_OFS_GRP_A:  s_d.rdata = cells[7:0];
				OMLR_OFS_GRP_B:  s_d.rdata = cells[15:8];
				OMLR_OFS_MASK_A: s_d.rdata = s_q.mask_a;
				OMLR_OFS_MASK_B: s_d.rdata = s_q.mask_b;
				default:         s_d.rdata = OMLR_UNMAPPED;
			endcase
		end
	end

	// masks drop to zero on every reset kind
	always_ff @(posedge clk_i) begin
		if (rst_i || por_i) begin
			s_q.mask_a <= OMLR_MASK_RST;
			s_q.mask_b <= OMLR_MASK_RST;
			s_q.rdata  <= OMLR_UNMAPPED;
			s_q.ack    <= 1'b0;
		end else begin
			s_q <= s_d;
		end
	end

	assign hrdata_o = s_q.rdata;
	assign hack_o   = s_q.ack;

	// =========================================================
	// macrocell flip-flops
	genvar gi;
	generate
		for (gi = 0; gi < OMLR_NCELL; gi++) begin : g_cell
			omlr_cell u_cell (
				.clk_i       (clk_i),
				.rst_i       (rst_i),
				.por_i       (por_i),
				.d_i         (cell_d_i[gi]),
				.pt_clk_i    (cell_clk_i[gi]),
				.preset_i    (cell_preset_i[gi]),
				.clear_i     (cell_clear_i[gi]),
				.load_i      (load[gi]),
				.load_data_i (load_data[gi]),
				.q_o         (cells[gi])
			);
		end
	endgenerate

	// feedback, bus read and pins all tap the same flop
	assign cell_fb_o = cells;

	// =========================================================
	// pin allocation
	omlr_alloc u_alloc (
		.clk_i         (clk_i),
		.rst_i         (rst_i | por_i), // pins idle under either reset
		.cell_q_i      (cells),
		.drive_en_i    (drive_en_i),
		.a_to_port_a_i (a_to_port_a_i),
		.b_to_port_c_i (b_to_port_c_i),
		.pkg80_i       (pkg80_i),
		.port_a_o      (port_a_o),
		.port_a_oe_o   (port_a_oe_o),
		.port_b_o      (port_b_o),
		.port_b_oe_o   (port_b_oe_o),
		.port_c_o      (port_c_o),
		.port_c_oe_o   (port_c_oe_o)
	);

	// =========================================================
	// checks
	sequence s_wr_grp_a;
		wr_grp_a && !por_i;
	endsequence

	sequence s_rd_grp_b;
		rd_hit && haddr_i == OMLR_OFS_GRP_B;
	endsequence

	a_por_clears: assert property (@(posedge clk_i)
		por_i |=> cells == 16'h0000)
		else $error("power-on reset left a cell set");

	a_mask_reset: assert property (@(posedge clk_i)
		rst_i || por_i |=> s_q.mask_a == 8'h00 && s_q.mask_b == 8'h00)
		else $error("mask not zero after reset");

	a_unmasked_load: assert property (@(posedge clk_i) disable iff (rst_i)
		s_wr_grp_a |=> ((cells[7:0] ^ $past(hwdata_i)) & ~$past(s_q.mask_a)) == 8'h00)
		else $error("unmasked cell missed host data");

	a_masked_hold: assert property (@(posedge clk_i) disable iff (rst_i)
		(s_wr_grp_a and (s_q.mask_a != 8'h00)) |-> (load[7:0] & s_q.mask_a) == 8'h00)
		else $error("masked cell was loaded");

	a_read_group: assert property (@(posedge clk_i) disable iff (rst_i)
		s_rd_grp_b |=> hack_o && hrdata_o == $past(cells[15:8]))
		else $error("group read wrong");

	a_mask_write: assert property (@(posedge clk_i) disable iff (rst_i)
		wr_hit && haddr_i == OMLR_OFS_MASK_B |=> s_q.mask_b == $past(hwdata_i) ##1
			hrdata_o == $past(hrdata_o) || $past(rd_hit))
		else $error("mask b write lost");

	a_unmapped_read: assert property (@(posedge clk_i) disable iff (rst_i)
		rd_hit && haddr_i[7:2] != 6'h08 |=> hrdata_o == 8'h00)
		else $error("unmapped read not zero");

	a_ack_pulse: assert property (@(posedge clk_i) disable iff (rst_i)
		hsel_i && (hwr_i || hrd_i) && !por_i && !hack_o |=> hack_o ##1 !hack_o)
		else $error("ack not one cycle");

endmodule

// ===== verif/omlr_host_model.sv
`timescale 1ns/10ps
module omlr_host_model (
	// clock
	input  wire logic       clk_i,
	// answer from block
	input  wire logic       hack_i,
	input  wire logic [7:0] hrdata_i,
	// request to block
	output logic            hsel_o,
	output logic [7:0]      haddr_o,
	output logic            hwr_o,
	output logic            hrd_o,
	output logic [7:0]      hwdata_o
);
	logic       tmo;
	logic [7:0] rd_q;
	// =========================================================
	// idle bus; data lines idle at a non-zero pattern
	initial begin
		tmo = 1'b0;
		hsel_o = 1'b0;
		haddr_o = 8'hFF;
		hwr_o = 1'b0;
		hrd_o = 1'b0;
		hwdata_o = 8'hA5;
	end
	// one access, entered at a falling edge, held until ack is sampled
	task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d);
		int n;
		hsel_o = 1'b1;
		haddr_o = a;
		hwr_o = w;
		hrd_o = !w;
		hwdata_o = d;
		n = 0;
		do begin
			@(posedge clk_i);
			n++;
		end while (hack_i !== 1'b1 && n < 8);
		rd_q = hrdata_i;
		if (n >= 8)
			tmo = 1'b1;
		@(negedge clk_i);
		hsel_o = 1'b0;
		hwr_o = 1'b0;
		hrd_o = 1'b0;
		haddr_o = ~a; // released lines do not keep the last value
		hwdata_o = ~d;
		@(negedge clk_i); // one idle cycle before the next request
	endtask
endmodule

// ===== verif/test_output_macrocell_load_read.sv
`timescale 1ns/10ps
module test_output_macrocell_load_read;
	import omlr_pkg::*;
	logic        clk_i = 1'b0;
	logic        rst_i = 1'b1;
	logic        por_i = 1'b1;
	logic [15:0] cd = 16'h0000, cc = 16'h0000, cp = 16'h0000, cr = 16'h0000;
	logic [15:0] den = 16'hFFFF;
	logic [7:0]  ta = 8'h00, tc = 8'hFF;
	logic        p80 = 1'b0;
	logic        hsel, hwr, hrd, hack;
	logic [7:0]  haddr, hwd, hrdat;
	logic [15:0] fb;
	logic [7:0]  pa, pao, pb, pbo, pc, pco;
	int          n_mismatch = 0;
	int          total_checks = 0;
	// =========================================================
	// 250 MHz clock
	always #2 clk_i = ~clk_i;
	omlr_host_model host (.clk_i(clk_i), .hack_i(hack), .hrdata_i(hrdat),
		.hsel_o(hsel), .haddr_o(haddr), .hwr_o(hwr), .hrd_o(hrd), .hwdata_o(hwd));
	omlr_top dut (.clk_i(clk_i), .rst_i(rst_i), .por_i(por_i), .hsel_i(hsel),
		.haddr_i(haddr), .hwr_i(hwr), .hrd_i(hrd), .hwdata_i(hwd), .hrdata_o(hrdat),
		.hack_o(hack), .cell_d_i(cd), .cell_clk_i(cc), .cell_preset_i(cp),
		.cell_clear_i(cr), .cell_fb_o(fb), .drive_en_i(den), .a_to_port_a_i(ta),
		.b_to_port_c_i(tc), .pkg80_i(p80), .port_a_o(pa), .port_a_oe_o(pao),
		.port_b_o(pb), .port_b_oe_o(pbo), .port_c_o(pc), .port_c_oe_o(pco));
	// =========================================================
	// verdict
	task automatic end_of_test();
		$display("checks %0d mismatches %0d", total_checks, n_mismatch);
		if (n_mismatch == 0 && total_checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
		total_checks++;
		if (g !== e) begin
			n_mismatch++;
			$display("Error %s expected %h seen %h", nm, e, g);
		end
	endtask
	// bus wrappers; a hung handshake ends the run
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		host.xfer(1'b1, a, d);
		if (host.tmo) begin
			n_mismatch++;
			end_of_test();
		end
	endtask
	task automatic rc(input logic [7:0] a, input logic [7:0] e, input string nm);
		host.xfer(1'b0, a, 8'h00);
		if (host.tmo) begin
			n_mismatch++;
			end_of_test();
		end
		chk(nm, e, host.rd_q);
	endtask
	// =========================================================
	// scenarios
	task automatic t_reset_values();
		rc(OMLR_OFS_GRP_A, 8'h00, "grp_a");
		rc(OMLR_OFS_GRP_B, 8'h00, "grp_b");
		rc(OMLR_OFS_MASK_A, 8'h00, "mask_a");
		rc(OMLR_OFS_MASK_B, 8'h00, "mask_b");
		rc(8'h24, OMLR_UNMAPPED, "unmapped");
	endtask
	task automatic t_load_read();
		wr(OMLR_OFS_GRP_A, 8'hA5);
		wr(OMLR_OFS_GRP_B, 8'h5A);
		rc(OMLR_OFS_GRP_A, 8'hA5, "grp_a");
		rc(OMLR_OFS_GRP_B, 8'h5A, "grp_b");
		chk("fb_b", 8'h5A, fb[15:8]);
	endtask
	task automatic t_mask();
		wr(OMLR_OFS_MASK_A, 8'h0F);
		rc(OMLR_OFS_MASK_A, 8'h0F, "mask_a");
		wr(OMLR_OFS_GRP_A, 8'hFF);
		rc(OMLR_OFS_GRP_A, 8'hF5, "grp_a");
		wr(OMLR_OFS_MASK_B, 8'h01);
		cd[8] = 1'b1; // masked cell clocked by its logic during the write
		cc[8] = 1'b1;
		wr(OMLR_OFS_GRP_B, 8'h00);
		rc(OMLR_OFS_GRP_B, 8'h01, "grp_b");
		rc(OMLR_OFS_GRP_A, 8'hF5, "grp_a");
		wr(OMLR_OFS_MASK_B, 8'h00);
		cc[8] = 1'b0;
	endtask
	task automatic t_host_wins();
		@(negedge clk_i);
		cd[9] = 1'b1;
		cc[9] = 1'b1; // logic edge in the very cycle of the load
		wr(OMLR_OFS_GRP_B, 8'h00);
		rc(OMLR_OFS_GRP_B, 8'h00, "grp_b");
		cp[10] = 1'b1;
		cr[10] = 1'b0;
		@(negedge clk_i);
		rc(OMLR_OFS_GRP_B, 8'h04, "preset");
		cp[10] = 1'b0;
		cr[10] = 1'b1;
		wr(OMLR_OFS_GRP_B, 8'h04);
		rc(OMLR_OFS_GRP_B, 8'h00, "clear");
		cr[10] = 1'b0;
		wr(OMLR_OFS_GRP_B, 8'hFF);
	endtask
	task automatic t_pins();
		@(negedge clk_i);
		@(negedge clk_i);
		chk("pc_oe", OMLR_PORTC_OK, pco);
		chk("pc", OMLR_PORTC_OK, pc);
		chk("pa_oe", 8'h00, pao);
		chk("pb_oe", 8'hFF, pbo);
		chk("pb", 8'hF5, pb);
		ta = 8'hFF;
		p80 = 1'b1;
		@(negedge clk_i);
		@(negedge clk_i);
		chk("pa", 8'hF5, pa);
		chk("pa_oe", 8'hFF, pao);
		chk("pb_oe", 8'h63, pbo);
		chk("pb", 8'h63, pb & pbo);
	endtask
	task automatic t_resets();
		wr(OMLR_OFS_MASK_A, 8'h0F);
		rst_i = 1'b1; // warm reset
		@(negedge clk_i);
		@(negedge clk_i);
		rst_i = 1'b0;
		@(negedge clk_i);
		rc(OMLR_OFS_GRP_A, 8'hF5, "grp_a");
		rc(OMLR_OFS_MASK_A, 8'h00, "mask_a");
		por_i = 1'b1;
		@(negedge clk_i);
		@(negedge clk_i);
		por_i = 1'b0;
		@(negedge clk_i);
		rc(OMLR_OFS_GRP_A, 8'h00, "grp_a");
		rc(OMLR_OFS_GRP_B, 8'h00, "grp_b");
	endtask
	// =========================================================
	// main sequence
	initial begin
		repeat (2) @(negedge clk_i);
		rst_i = 1'b0;
		por_i = 1'b0;
		@(negedge clk_i);
		t_reset_values();
		t_load_read();
		t_mask();
		t_host_wins();
		t_pins();
		t_resets();
		end_of_test();
	end
endmodule
